// *** ivt_pkg.sv ***
// Constants and types shared by the interval timer files
`default_nettype none

package ivt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int BE_W = 2;
   localparam int NUM_CH = 2;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_RUN_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CH_BASE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CH_STRIDE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_CSR = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_COR = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h28;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int BIT_FLAG = 7;
   localparam int BIT_IRQ_EN = 6;
   localparam int BIT_SEL_HI = 1;
   localparam int BIT_SEL_LO = 0;
   localparam int SEL_W = 2;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [DATA_W-1:0] RST_CNT = 16'h0000;
   localparam logic [DATA_W-1:0] RST_COR = 16'hffff;
   localparam logic [NUM_CH-1:0] RST_RUN = 2'h0;
   localparam logic [SEL_W-1:0] RST_SEL = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Prescaler: divide by 8, 32, 128, 512
   localparam int NUM_RATES = 4;
   localparam int PRE_W = 9;
   localparam logic [PRE_W-1:0] PRE_MASK_8 = 9'h007;
   localparam logic [PRE_W-1:0] PRE_MASK_32 = 9'h01f;
   localparam logic [PRE_W-1:0] PRE_MASK_128 = 9'h07f;
   localparam logic [PRE_W-1:0] PRE_MASK_512 = 9'h1ff;

   ////////////////////////////////////////////////////////////////////////
   // Bus request carrier
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [BE_W-1:0] be;
      logic wr;
      logic rd;
   } ivt_bus_req_type;

endpackage

`default_nettype wire

// *** ivt_prescale.sv ***
// Free-running prescaler giving the four count-rate enable pulses
`timescale 1ns/1ps
`default_nettype none

module ivt_prescale (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic SRST_I,
   // Rate pulses: index 0 is /8, 3 is /512
   output logic [ivt_pkg::NUM_RATES-1:0] ticks_o
);

   logic [ivt_pkg::PRE_W-1:0] pre_q;
   logic [ivt_pkg::NUM_RATES-1:0] ticks_d;

   assign ticks_d[0] = (pre_q & ivt_pkg::PRE_MASK_8) == ivt_pkg::PRE_MASK_8;
   assign ticks_d[1] =
      (pre_q & ivt_pkg::PRE_MASK_32) == ivt_pkg::PRE_MASK_32;
   assign ticks_d[2] =
      (pre_q & ivt_pkg::PRE_MASK_128) == ivt_pkg::PRE_MASK_128;
   assign ticks_d[3] =
      (pre_q & ivt_pkg::PRE_MASK_512) == ivt_pkg::PRE_MASK_512;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         pre_q <= '0;
         ticks_o <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
         ticks_o <= ticks_d;
      end
   end

endmodule // ivt_prescale

`default_nettype wire

// *** ivt_top.sv ***
// Two-channel compare-match interval timer with register port
//
// How it works
// - There are two channels, each with a 16-bit up-counter, a 16-bit match constant and a control/status register.
// - A shared run-control register holds run bit 1 for channel 1 and bit 0 for channel 0; 1 counts, 0 stops.
// - Control/status bits 1:0 select the rate: 00 clock/8, 01 clock/32, 10 clock/128, 11 clock/512.
// - While running, a counter increments once per tick of its selected rate.
// - On a match the counter clears to zero, the match flag sets, and counting goes on from zero.
// - The match fires on the tick after equality is reached, the same tick that reloads zero.
// - The match flag is bit 7, the interrupt enable bit 6, and the request is high when both are 1.
// - Each channel drives its own match interrupt line.
// - The flag clears only by a 0 write after it was read as 1; writing 1 has no effect.
// - Reset or standby zero run-control, control/status and counters, and set match constants to all ones.
// - A match clear in the same cycle as a counter write wins and the written value is lost.
// - A full-word counter write in a tick cycle loads the value and the increment is dropped.
// - A byte counter write in a tick cycle loads that byte, the other byte holds, the increment is lost.
// - A counter or constant write while stopped is compared one cycle later; if equal, the flag sets and the counter clears to zero.
// - Reserved bits read as zero and should be written as zero.
`timescale 1ns/1ps
`default_nettype none

module ivt_top #(
   parameter int CNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic SRST_I,
   // Standby request pin
   input wire logic STANDBY_I,
   // Register port
   input wire logic [ivt_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [ivt_pkg::DATA_W-1:0] WDATA_I,
   input wire logic [ivt_pkg::BE_W-1:0] BE_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [ivt_pkg::DATA_W-1:0] RDATA_O,
   // Interrupts
   output logic [ivt_pkg::NUM_CH-1:0] MATCH_IRQ_O,
   output logic IRQ_O
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check

   if (CNT_WIDTH != ivt_pkg::DATA_W) begin : g_bad_width
      $error("CNT_WIDTH must equal the 16-bit register width");
   end

   localparam int last_ch_off = int'(ivt_pkg::OFF_CH_BASE) +
      int'(ivt_pkg::OFF_CH_STRIDE) * (ivt_pkg::NUM_CH - 1) +
      int'(ivt_pkg::OFF_COR);

   if (last_ch_off >= int'(ivt_pkg::OFF_IRQ_STATUS)) begin : g_bad_map
      $error("channel registers overlap the interrupt registers");
   end

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic hit(
      input logic [ivt_pkg::ADDR_W-1:0] addr,
      input logic [ivt_pkg::ADDR_W-1:0] off
   );
      hit = (addr == off);
   endfunction

   function automatic logic [ivt_pkg::ADDR_W-1:0] ch_off(
      input int ch,
      input logic [ivt_pkg::ADDR_W-1:0] off
   );
      ch_off = ivt_pkg::OFF_CH_BASE + off +
         ivt_pkg::OFF_CH_STRIDE * ivt_pkg::ADDR_W'(ch);
   endfunction

   // Byte-lane merge of a write into an old value
   function automatic logic [ivt_pkg::DATA_W-1:0] merge(
      input logic [ivt_pkg::DATA_W-1:0] old_v,
      input logic [ivt_pkg::DATA_W-1:0] new_v,
      input logic [ivt_pkg::BE_W-1:0] be
   );
      merge = old_v;
      for (int b = 0; b < ivt_pkg::BE_W; b++) begin
         if (be[b]) begin
            merge[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Standby pin synchroniser

   logic stby_meta_q;
   logic stby_q;
   logic init_w;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         stby_meta_q <= 1'b0;
         stby_q <= 1'b0;
      end else begin
         stby_meta_q <= STANDBY_I;
         stby_q <= stby_meta_q;
      end
   end

   assign init_w = SRST_I | stby_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus request and prescaler

   ivt_pkg::ivt_bus_req_type req_w;
   logic [ivt_pkg::NUM_RATES-1:0] ticks_w;

   assign req_w.addr = ADDR_I;
   assign req_w.wdata = WDATA_I;
   assign req_w.be = BE_I;
   assign req_w.wr = WR_I;
   assign req_w.rd = RD_I;

   ivt_prescale u_prescale (
      .CLK_I(CLK_I),
      .SRST_I(init_w),
      .ticks_o(ticks_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // Run control and global decode

   logic [ivt_pkg::NUM_CH-1:0] run_q;
   logic [ivt_pkg::NUM_CH-1:0] run_d;
   logic wr_lo_w;
   logic wr_run_w;
   logic wr_iclr_w;
   logic wr_ien_w;

   assign wr_lo_w = req_w.wr & req_w.be[0];
   assign wr_run_w = wr_lo_w & hit(req_w.addr, ivt_pkg::OFF_RUN_CTRL);
   assign wr_iclr_w = wr_lo_w & hit(req_w.addr, ivt_pkg::OFF_IRQ_CLEAR);
   assign wr_ien_w = wr_lo_w & hit(req_w.addr, ivt_pkg::OFF_IRQ_ENABLE);

   assign run_d = wr_run_w ? req_w.wdata[ivt_pkg::NUM_CH-1:0] : run_q;

   always_ff @(posedge CLK_I) begin
      if (init_w) begin
         run_q <= ivt_pkg::RST_RUN;
      end else begin
         run_q <= run_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels

   logic [ivt_pkg::DATA_W-1:0] cnt_q [ivt_pkg::NUM_CH];
   logic [ivt_pkg::DATA_W-1:0] cnt_d [ivt_pkg::NUM_CH];
   logic [ivt_pkg::DATA_W-1:0] cor_q [ivt_pkg::NUM_CH];
   logic [ivt_pkg::DATA_W-1:0] cor_d [ivt_pkg::NUM_CH];
   logic [ivt_pkg::SEL_W-1:0] sel_q [ivt_pkg::NUM_CH];
   logic [ivt_pkg::SEL_W-1:0] sel_d [ivt_pkg::NUM_CH];
   logic [ivt_pkg::DATA_W-1:0] csr_rd_w [ivt_pkg::NUM_CH];
   logic [ivt_pkg::NUM_CH-1:0] flag_q;
   logic [ivt_pkg::NUM_CH-1:0] flag_d;
   logic [ivt_pkg::NUM_CH-1:0] ien_q;
   logic [ivt_pkg::NUM_CH-1:0] ien_d;
   logic [ivt_pkg::NUM_CH-1:0] armed_q;
   logic [ivt_pkg::NUM_CH-1:0] armed_d;
   logic [ivt_pkg::NUM_CH-1:0] same_wr_q;
   logic [ivt_pkg::NUM_CH-1:0] same_wr_d;
   logic [ivt_pkg::NUM_CH-1:0] match_w;
   logic [ivt_pkg::NUM_CH-1:0] irq_line_d;

   for (genvar ch = 0; ch < ivt_pkg::NUM_CH; ch++) begin : g_ch
      logic hit_csr_w;
      logic hit_cnt_w;
      logic hit_cor_w;
      logic wr_csr_w;
      logic wr_cnt_w;
      logic wr_cor_w;
      logic rd_csr_w;
      logic tick_w;
      logic equal_w;
      logic stop_eq_w;
      logic clr_flag_w;

      assign hit_csr_w = hit(req_w.addr, ch_off(ch, ivt_pkg::OFF_CSR));
      assign hit_cnt_w = hit(req_w.addr, ch_off(ch, ivt_pkg::OFF_CNT));
      assign hit_cor_w = hit(req_w.addr, ch_off(ch, ivt_pkg::OFF_COR));
      assign wr_csr_w = wr_lo_w & hit_csr_w;
      assign wr_cnt_w = req_w.wr & hit_cnt_w & (|req_w.be);
      assign wr_cor_w = req_w.wr & hit_cor_w & (|req_w.be);
      assign rd_csr_w = req_w.rd & hit_csr_w;

      assign tick_w = run_q[ch] & ticks_w[sel_q[ch]];
      assign equal_w = (cnt_q[ch] == cor_q[ch]);

      assign same_wr_d[ch] = ~run_q[ch] & (wr_cnt_w | wr_cor_w);
      assign stop_eq_w = ~run_q[ch] & same_wr_q[ch] & equal_w;

      assign match_w[ch] = (tick_w & equal_w) | stop_eq_w;

      assign cnt_d[ch] = match_w[ch] ? ivt_pkg::RST_CNT :
                         wr_cnt_w ? merge(cnt_q[ch], req_w.wdata, req_w.be) :
                         tick_w ? cnt_q[ch] + 1'b1 :
                         cnt_q[ch];

      assign cor_d[ch] = wr_cor_w ?
         merge(cor_q[ch], req_w.wdata, req_w.be) : cor_q[ch];

      assign sel_d[ch] = wr_csr_w ?
         req_w.wdata[ivt_pkg::BIT_SEL_HI:ivt_pkg::BIT_SEL_LO] : sel_q[ch];
      assign ien_d[ch] = wr_csr_w ?
         req_w.wdata[ivt_pkg::BIT_IRQ_EN] : ien_q[ch];

      assign clr_flag_w = wr_csr_w & armed_q[ch] &
         ~req_w.wdata[ivt_pkg::BIT_FLAG];
      assign flag_d[ch] = match_w[ch] | (flag_q[ch] & ~clr_flag_w);
      assign armed_d[ch] = (rd_csr_w & flag_q[ch]) |
         (armed_q[ch] & ~clr_flag_w & flag_q[ch]);

      assign irq_line_d[ch] = flag_d[ch] & ien_d[ch];

      always_comb begin
         csr_rd_w[ch] = '0;
         csr_rd_w[ch][ivt_pkg::BIT_FLAG] = flag_q[ch];
         csr_rd_w[ch][ivt_pkg::BIT_IRQ_EN] = ien_q[ch];
         csr_rd_w[ch][ivt_pkg::BIT_SEL_HI:ivt_pkg::BIT_SEL_LO] = sel_q[ch];
      end

      always_ff @(posedge CLK_I) begin
         if (init_w) begin
            cnt_q[ch] <= ivt_pkg::RST_CNT;
            cor_q[ch] <= ivt_pkg::RST_COR;
            sel_q[ch] <= ivt_pkg::RST_SEL;
            flag_q[ch] <= 1'b0;
            ien_q[ch] <= 1'b0;
            armed_q[ch] <= 1'b0;
            same_wr_q[ch] <= 1'b0;
         end else begin
            cnt_q[ch] <= cnt_d[ch];
            cor_q[ch] <= cor_d[ch];
            sel_q[ch] <= sel_d[ch];
            flag_q[ch] <= flag_d[ch];
            ien_q[ch] <= ien_d[ch];
            armed_q[ch] <= armed_d[ch];
            same_wr_q[ch] <= same_wr_d[ch];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Summary interrupt: sticky status, enable, write-one clear

   logic [ivt_pkg::NUM_CH-1:0] ist_q;
   logic [ivt_pkg::NUM_CH-1:0] ist_d;
   logic [ivt_pkg::NUM_CH-1:0] ien_all_q;
   logic [ivt_pkg::NUM_CH-1:0] ien_all_d;
   logic [ivt_pkg::NUM_CH-1:0] iclr_w;
   logic irq_d;

   assign iclr_w = wr_iclr_w ? req_w.wdata[ivt_pkg::NUM_CH-1:0] : '0;
   assign ist_d = match_w | (ist_q & ~iclr_w);
   assign ien_all_d = wr_ien_w ? req_w.wdata[ivt_pkg::NUM_CH-1:0] : ien_all_q;
   assign irq_d = |(ist_d & ien_all_d);

   always_ff @(posedge CLK_I) begin
      if (init_w) begin
         ist_q <= '0;
         ien_all_q <= '0;
      end else begin
         ist_q <= ist_d;
         ien_all_q <= ien_all_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data mux

   logic [ivt_pkg::DATA_W-1:0] rd_mux_w;
   logic [ivt_pkg::DATA_W-1:0] rd_ch_w [ivt_pkg::NUM_CH];
   logic [ivt_pkg::DATA_W-1:0] rd_any_w;

   for (genvar ch = 0; ch < ivt_pkg::NUM_CH; ch++) begin : g_rd
      assign rd_ch_w[ch] =
         hit(req_w.addr, ch_off(ch, ivt_pkg::OFF_CSR)) ? csr_rd_w[ch] :
         hit(req_w.addr, ch_off(ch, ivt_pkg::OFF_CNT)) ? cnt_q[ch] :
         hit(req_w.addr, ch_off(ch, ivt_pkg::OFF_COR)) ? cor_q[ch] :
         '0;
   end

   // Merge of channel read values
   always_comb begin
      rd_any_w = '0;
      for (int c = 0; c < ivt_pkg::NUM_CH; c++) begin
         rd_any_w = rd_any_w | rd_ch_w[c];
      end
   end

   assign rd_mux_w =
      hit(req_w.addr, ivt_pkg::OFF_RUN_CTRL) ?
         {{(ivt_pkg::DATA_W-ivt_pkg::NUM_CH){1'b0}}, run_q} :
      hit(req_w.addr, ivt_pkg::OFF_IRQ_STATUS) ?
         {{(ivt_pkg::DATA_W-ivt_pkg::NUM_CH){1'b0}}, ist_q} :
      hit(req_w.addr, ivt_pkg::OFF_IRQ_ENABLE) ?
         {{(ivt_pkg::DATA_W-ivt_pkg::NUM_CH){1'b0}}, ien_all_q} :
      rd_any_w;

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always_ff @(posedge CLK_I) begin
      if (init_w) begin
         RDATA_O <= '0;
         MATCH_IRQ_O <= '0;
         IRQ_O <= 1'b0;
      end else begin
         RDATA_O <= req_w.rd ? rd_mux_w : '0;
         MATCH_IRQ_O <= irq_line_d;
         IRQ_O <= irq_d;
      end
   end

endmodule // ivt_top

`default_nettype wire

// *** ivt_top_properties.sv ***
// Port-level assertions for the interval timer
`timescale 1ns/1ps
`default_nettype none

module ivt_top_properties #(
   parameter int CNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic STANDBY_I,
   // Register port
   input wire logic [ivt_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [ivt_pkg::DATA_W-1:0] WDATA_I,
   input wire logic [ivt_pkg::BE_W-1:0] BE_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [ivt_pkg::DATA_W-1:0] RDATA_O,
   // Interrupts
   input wire logic [ivt_pkg::NUM_CH-1:0] MATCH_IRQ_O,
   input wire logic IRQ_O
);
   //////////////////////////////////////////////////////////////////////
   // Standby tail, covers the synchroniser delay
   logic [3:0] sb_q;
   logic quiet;
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         sb_q <= 4'h0;
      end else begin
         sb_q <= {sb_q[2:0], STANDBY_I};
      end
   end
   assign quiet = SRST_I | STANDBY_I | (|sb_q);

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (quiet);

   //////////////////////////////////////////////////////////////////////
   // Assertions
   a_reset_quiet: assert property ($past(SRST_I) |->
      !IRQ_O && MATCH_IRQ_O == 2'h0 && RDATA_O == 16'h0000)
      else $error("outputs not quiet after reset");
   a_reset_const: assert property ($past(SRST_I) && RD_I &&
      ADDR_I == 8'h0c |=> RDATA_O == 16'hffff)
      else $error("constant not all ones after reset");
   a_run_reserved: assert property (RD_I && ADDR_I == 8'h00
      |=> RDATA_O[15:2] == 14'h0000)
      else $error("run control reserved bits set");
   a_csr_reserved: assert property (RD_I && (ADDR_I == 8'h04 ||
      ADDR_I == 8'h10) |=> RDATA_O[15:8] == 8'h00 && RDATA_O[5:2] == 4'h0)
      else $error("status reserved bits set");
   a_unmapped_zero: assert property (RD_I && ADDR_I == 8'h30
      |=> RDATA_O == 16'h0000)
      else $error("unmapped read not zero");
   a_irq_level: assert property (RD_I && ADDR_I == 8'h04
      ##1 RDATA_O[7:6] == 2'h3 |-> MATCH_IRQ_O[0])
      else $error("request low with flag and enable set");
   a_irq_own: assert property (RD_I && ADDR_I == 8'h10
      ##1 !RDATA_O[6] |-> !MATCH_IRQ_O[1])
      else $error("channel 1 request without enable");
   a_flag_keep: assert property (RD_I && ADDR_I == 8'h04
      ##1 (RDATA_O[7] && WR_I && ADDR_I == 8'h04 && BE_I[0] && WDATA_I[7])
      ##1 (RD_I && ADDR_I == 8'h04) |=> RDATA_O[7])
      else $error("flag lost on write of one");
   a_run_readback: assert property (WR_I && ADDR_I == 8'h00 && BE_I[0]
      ##1 RD_I && ADDR_I == 8'h00 |=> RDATA_O[1:0] == $past(WDATA_I[1:0], 2))
      else $error("run bits not stored");
   a_const_readback: assert property (WR_I && ADDR_I == 8'h0c
      && BE_I == 2'h3 ##1 RD_I && ADDR_I == 8'h0c
      |=> RDATA_O == $past(WDATA_I, 2))
      else $error("constant not stored");

endmodule // ivt_top_properties

bind ivt_top ivt_top_properties #(.CNT_WIDTH(CNT_WIDTH)) u_props (
   .CLK_I(CLK_I), .SRST_I(SRST_I), .STANDBY_I(STANDBY_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .BE_I(BE_I), .WR_I(WR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .MATCH_IRQ_O(MATCH_IRQ_O), .IRQ_O(IRQ_O)
);

`default_nettype wire

// *** tb_ivt_top.sv ***
// Self-checking testbench for the interval timer
`timescale 1ns/1ps
`default_nettype none

module tb_ivt_top;
   //////////////////////////////////////////////////////////////////////
   // Ports and bench state
   logic CLK_I, SRST_I, STANDBY_I, WR_I, RD_I, IRQ_O, rd_d;
   logic [7:0] ADDR_I, c_a;
   logic [15:0] WDATA_I, RDATA_O, w, b, e_v, m_v;
   logic [1:0] BE_I, MATCH_IRQ_O;
   logic [2:0] smp;
   logic [31:0] seed = 32'h74b25841;
   logic [15:0] exp_q[$], msk_q[$];
   int miscompares = 0, checks = 0, cyc = 0, t0, t1;

   ivt_top #(.CNT_WIDTH(16)) dut (
      .CLK_I(CLK_I), .SRST_I(SRST_I), .STANDBY_I(STANDBY_I),
      .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .BE_I(BE_I), .WR_I(WR_I),
      .RD_I(RD_I), .RDATA_O(RDATA_O), .MATCH_IRQ_O(MATCH_IRQ_O),
      .IRQ_O(IRQ_O)
   );

   initial begin
      CLK_I = 1'b0;
      forever #25 CLK_I = ~CLK_I;
   end

   //////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] ca(input int ch, input logic [7:0] o);
      return ivt_pkg::OFF_CH_BASE + 8'(ch) * ivt_pkg::OFF_CH_STRIDE + o;
   endfunction
   task automatic check(input string nm, input logic [15:0] seen,
         input logic [15:0] ex);
      checks++;
      if (seen !== ex) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic bus(input logic wv, input logic rv, input logic [7:0] a,
         input logic [15:0] d, input logic [1:0] be);
      WR_I <= wv;
      RD_I <= rv;
      ADDR_I <= a;
      WDATA_I <= d;
      BE_I <= be;
      @(posedge CLK_I);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, 1'b0, a, d, 2'h3);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
         input logic [15:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus(1'b0, 1'b1, a, 16'h0000, 2'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 8'h00, 16'h0000, 2'h0);
   endtask
   task automatic wait_irq(input int ch, output int t);
      int n;
      n = 0;
      while (smp[ch] !== 1'b1 && n < 3000) begin
         @(posedge CLK_I);
         n++;
      end
      t = cyc;
      check("match irq", 16'(smp[ch]), 16'h0001);
   endtask
   task automatic final_report();
      $display("TB: checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////
   // Watchdog and read-data monitor
   always @(posedge CLK_I) begin
      rd_d <= RD_I;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         final_report();
      end
   end
   always @(negedge CLK_I) begin
      smp <= {IRQ_O, MATCH_IRQ_O};
      if (rd_d === 1'b1) begin
         e_v = exp_q.pop_front();
         m_v = msk_q.pop_front();
         check("read data", RDATA_O & m_v, e_v);
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      SRST_I <= 1'b1;
      STANDBY_I <= 1'b0;
      idle(16);
      SRST_I <= 1'b0;
      rd(8'h0c, 16'hffff, 16'hffff);
      rd(8'h10, 16'h0000, 16'hffff);
      rd(8'h14, 16'h0000, 16'hffff);
      rd(8'h00, 16'h0000, 16'hffff);
      wr(8'h00, 16'h0003);
      rd(8'h00, 16'h0003, 16'hffff);
      wr(8'h04, 16'h00c3);
      rd(8'h04, 16'h0043, 16'hffff);
      wr(8'h00, 16'h0000);
      wr(8'h30, 16'hffff);
      rd(8'h30, 16'h0000, 16'hffff);
      w = seed[15:0] | 16'h8000;
      seed = lfsr(seed);
      wr(8'h0c, w);
      rd(8'h0c, w, 16'hffff);
      $display("TB: register test done");
      wr(8'h28, 16'h0003);
      for (int ch = 0; ch < 2; ch++) begin
         for (int s = 0; s < 4; s++) begin
            c_a = ca(ch, ivt_pkg::OFF_CSR);
            wr(c_a, 16'h0040 | 16'(s));
            wr(ca(ch, ivt_pkg::OFF_CNT), 16'h0000);
            wr(ca(ch, ivt_pkg::OFF_COR), 16'h0003);
            wr(8'h00, 16'h0001 << ch);
            idle(1);
            wait_irq(ch, t0);
            check("other irq", 16'(smp[1 - ch]), 16'h0000);
            check("summary irq", 16'(smp[2]), 16'h0001);
            rd(c_a, 16'h00c0 | 16'(s), 16'h00ff);
            wr(c_a, 16'h0040 | 16'(s));
            wr(8'h24, 16'h0001 << ch);
            idle(2);
            check("irq cleared", 16'(smp), 16'h0000);
            wait_irq(ch, t1);
            check("period", 16'(t1 - t0), 16'(32 << (2 * s)));
            wr(8'h28, 16'h0000);
            idle(2);
            check("masked irq", 16'(smp[2]), 16'h0000);
            rd(8'h20, 16'h0001 << ch, 16'h0003);
            wr(8'h00, 16'h0000);
            rd(c_a, 16'h0000, 16'h0000);
            wr(c_a, 16'h0000);
            wr(8'h24, 16'h0003);
            wr(8'h28, 16'h0003);
         end
      end
      $display("TB: rate test done");
      wr(8'h0c, 16'hffff);
      w = {1'b0, seed[14:8], 8'h10};
      b = {9'h000, seed[6:0]};
      seed = lfsr(seed);
      wr(8'h00, 16'h0001);
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, 1'b0, 8'h08, i < 8 ? w : b, i < 8 ? 2'h3 : 2'h1);
         rd(8'h08, i < 8 ? w : {w[15:8], b[7:0]}, 16'hffff);
         idle(1);
      end
      $display("TB: conflict test done");
      wr(8'h00, 16'h0000);
      wr(8'h08, w);
      wr(8'h0c, w);
      wr(8'h08, 16'h1234);
      rd(8'h08, 16'h0000, 16'hffff);
      rd(8'h04, 16'h0080, 16'h00ff);
      wr(8'h04, 16'h0080);
      rd(8'h04, 16'h0080, 16'h00ff);
      wr(8'h04, 16'h0000);
      rd(8'h04, 16'h0000, 16'h00ff);
      $display("TB: flag test done");
      wr(8'h18, 16'h1234);
      wr(8'h00, 16'h0003);
      STANDBY_I <= 1'b1;
      idle(4);
      STANDBY_I <= 1'b0;
      idle(6);
      rd(8'h18, 16'hffff, 16'hffff);
      rd(8'h00, 16'h0000, 16'hffff);
      idle(2);
      $display("TB: standby test done");
      final_report();
   end

endmodule // tb_ivt_top

`default_nettype wire
